// file: logic/mms_status_map.sv
/*
  Read-only monitor word bank of a multi-axis motion module.
  Assumes status inputs are synchronous to clk and that the host issues
  one memory read or write command at a time with hexadecimal addresses.
*/
`timescale 1ns/1ps
`default_nettype none

module mms_status_map
  import mms_pkg::*;
#(
  parameter bit FOUR_AXIS = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic memory_write_command,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_wdata,
  input wire logic system_fault_active,
  input wire logic [CODE_W-1:0] system_fault_in,
  input wire logic [3:0][CODE_W-1:0] task_fault_in,
  input wire logic [3:0][CODE_W-1:0] axis_fault_in,
  input wire logic [3:0] gp_in,
  input wire logic [3:0] gp_out,
  input wire logic [3:0] ccw_limit,
  input wire logic [3:0] cw_limit,
  input wire logic [3:0] origin_near,
  input wire logic [3:0] estop,
  input wire logic [3:0] drv_alarm,
  input wire logic [3:0] run_out,
  input wire logic [3:0] alarm_reset_out,
  input wire logic [3:0] sensor_on_out,
  input wire logic program_running,
  input wire logic [PROG_W-1:0] program_number,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_miss,
  output logic wr_done
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [HALF_W-1:0] io_half(input int ax, input logic [3:0] gi,
      input logic [3:0] go, input logic [3:0] ccw, input logic [3:0] cw,
      input logic [3:0] org, input logic [3:0] es, input logic [3:0] da,
      input logic [3:0] ro, input logic [3:0] ar, input logic [3:0] so);
    logic [HALF_W-1:0] h;
    h = '0;
    h[IO_GP_IN] = gi[ax];
    h[IO_GP_OUT] = go[ax];
    h[IO_CCW_LIMIT] = ccw[ax];
    h[IO_CW_LIMIT] = cw[ax];
    h[IO_ORIGIN] = org[ax];
    h[IO_ESTOP] = es[ax];
    h[IO_DRV_ALARM] = da[ax];
    h[IO_RUN_OUT] = ro[ax];
    h[IO_ALARM_RESET_OUT] = ar[ax];
    h[IO_SENSOR_ON_OUT] = so[ax];
    return h;
  endfunction

  function automatic logic [DATA_W-1:0] low_word_half(input logic [HALF_W-1:0] v);
    return {{(DATA_W-HALF_W){1'b0}}, v};
  endfunction

  // ----------------------------------------------------------------
  // monitor words
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] system_fault_code;
  logic [3:0][CODE_W-1:0] task_fault_code;
  logic [3:0][CODE_W-1:0] axis_fault_code;
  logic [DATA_W-1:0] axes_one_two_io_status;
  logic [DATA_W-1:0] axes_three_four_io_status;
  logic [PROG_W-1:0] task_one_running_program;
  logic [CODE_W-1:0] next_system_fault_code;
  logic [3:0][CODE_W-1:0] next_task_fault_code;
  logic [3:0][CODE_W-1:0] next_axis_fault_code;
  logic [DATA_W-1:0] next_axes_one_two_io_status;
  logic [DATA_W-1:0] next_axes_three_four_io_status;
  logic [PROG_W-1:0] next_task_one_running_program;

  // words follow only their own inputs; no command term appears here
  always_comb begin
    next_system_fault_code = system_fault_active ? system_fault_in : CODE_NONE;
    next_task_fault_code = task_fault_in;
    next_axis_fault_code = axis_fault_in;
    if (!FOUR_AXIS) begin
      next_task_fault_code[2] = CODE_NONE;
      next_task_fault_code[3] = CODE_NONE;
      next_axis_fault_code[2] = CODE_NONE;
      next_axis_fault_code[3] = CODE_NONE;
    end
    next_axes_one_two_io_status = {
      io_half(1, gp_in, gp_out, ccw_limit, cw_limit, origin_near, estop, drv_alarm,
              run_out, alarm_reset_out, sensor_on_out),
      io_half(0, gp_in, gp_out, ccw_limit, cw_limit, origin_near, estop, drv_alarm,
              run_out, alarm_reset_out, sensor_on_out)};
    next_axes_three_four_io_status = {
      io_half(3, gp_in, gp_out, ccw_limit, cw_limit, origin_near, estop, drv_alarm,
              run_out, alarm_reset_out, sensor_on_out),
      io_half(2, gp_in, gp_out, ccw_limit, cw_limit, origin_near, estop, drv_alarm,
              run_out, alarm_reset_out, sensor_on_out)};
    if (!FOUR_AXIS) begin
      next_axes_three_four_io_status = WORD_RESET;
    end
    next_task_one_running_program = task_one_running_program;
    // out-of-range numbers are dropped so the word never leaves 0..999
    if (program_running && program_number <= PROG_MAX) begin
      next_task_one_running_program = program_number;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      system_fault_code <= CODE_NONE;
      task_fault_code <= '0;
      axis_fault_code <= '0;
      axes_one_two_io_status <= WORD_RESET;
      axes_three_four_io_status <= WORD_RESET;
      task_one_running_program <= PROG_RESET;
    end else begin
      system_fault_code <= next_system_fault_code;
      task_fault_code <= next_task_fault_code;
      axis_fault_code <= next_axis_fault_code;
      axes_one_two_io_status <= next_axes_one_two_io_status;
      axes_three_four_io_status <= next_axes_three_four_io_status;
      task_one_running_program <= next_task_one_running_program;
    end
  end

  // ----------------------------------------------------------------
  // memory command answer
  // ----------------------------------------------------------------
  logic next_rd_valid;
  logic [DATA_W-1:0] next_rd_data;
  logic next_rd_miss;
  logic next_wr_done;
  logic [DATA_W-1:0] dec_data;
  logic dec_hit;

  // write data is accepted and discarded: every word here is read-only
  always_comb begin
    dec_data = WORD_RESET;
    dec_hit = 1'b1;
    if (cmd_addr == OFS_SYSTEM_FAULT_CODE) begin
      dec_data = low_word_half(system_fault_code);
    end else if (cmd_addr == OFS_TASK_ONE_FAULT_CODE) begin
      dec_data = low_word_half(task_fault_code[0]);
    end else if (cmd_addr == OFS_TASK_TWO_FAULT_CODE) begin
      dec_data = low_word_half(task_fault_code[1]);
    end else if (FOUR_AXIS && cmd_addr == OFS_TASK_THREE_FAULT_CODE) begin
      dec_data = low_word_half(task_fault_code[2]);
    end else if (FOUR_AXIS && cmd_addr == OFS_TASK_FOUR_FAULT_CODE) begin
      dec_data = low_word_half(task_fault_code[3]);
    end else if (cmd_addr == OFS_AXIS_ONE_FAULT_CODE) begin
      dec_data = low_word_half(axis_fault_code[0]);
    end else if (cmd_addr == OFS_AXIS_TWO_FAULT_CODE) begin
      dec_data = low_word_half(axis_fault_code[1]);
    end else if (FOUR_AXIS && cmd_addr == OFS_AXIS_THREE_FAULT_CODE) begin
      dec_data = low_word_half(axis_fault_code[2]);
    end else if (FOUR_AXIS && cmd_addr == OFS_AXIS_FOUR_FAULT_CODE) begin
      dec_data = low_word_half(axis_fault_code[3]);
    end else if (cmd_addr == OFS_AXES_ONE_TWO_IO_STATUS) begin
      dec_data = axes_one_two_io_status;
    end else if (FOUR_AXIS && cmd_addr == OFS_AXES_THREE_FOUR_IO_STATUS) begin
      dec_data = axes_three_four_io_status;
    end else if (cmd_addr == OFS_TASK_ONE_RUNNING_PROGRAM) begin
      dec_data = {{(DATA_W-PROG_W){1'b0}}, task_one_running_program};
    end else begin
      dec_hit = 1'b0;
    end
    next_rd_valid = cmd_valid && !memory_write_command;
    next_rd_data = (next_rd_valid && dec_hit) ? dec_data : WORD_RESET;
    next_rd_miss = next_rd_valid && !dec_hit;
    next_wr_done = cmd_valid && memory_write_command;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= WORD_RESET;
      rd_miss <= 1'b0;
      wr_done <= 1'b0;
    end else begin
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      rd_miss <= next_rd_miss;
      wr_done <= next_wr_done;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  write_no_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && memory_write_command |=> wr_done && !rd_valid && rd_data == WORD_RESET)
    else $error("write command produced read data");

  absent_words_a: assert property (@(posedge clk) disable iff (!rst_n)
    !FOUR_AXIS && cmd_valid && !memory_write_command
    && cmd_addr == OFS_AXIS_THREE_FAULT_CODE |=> rd_valid && rd_miss && rd_data == WORD_RESET)
    else $error("absent axis word answered in two-axis build");

  sys_code_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    system_fault_active |=> system_fault_code == $past(system_fault_in))
    else $error("system fault code not loaded");

  sys_code_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    !system_fault_active ##1 !system_fault_active |-> system_fault_code == CODE_NONE)
    else $error("system fault code nonzero while normal");

  task_two_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !memory_write_command && cmd_addr == OFS_TASK_TWO_FAULT_CODE
    |=> rd_data == low_word_half($past(task_fault_code[1])))
    else $error("task two fault word wrong");

  axis_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> axis_fault_code[1] == $past(axis_fault_in[1]))
    else $error("axis two fault word not following");

  io_unused_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    axes_one_two_io_status[7:2] == 6'h00 && axes_one_two_io_status[23:18] == 6'h00)
    else $error("unused i/o bits set");

  io_bits_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> axes_one_two_io_status[HALF_W + IO_ESTOP] == $past(estop[1])
    && axes_one_two_io_status[IO_CCW_LIMIT] == $past(ccw_limit[0]))
    else $error("limit or stop bit mismatch");

  io_outs_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> axes_one_two_io_status[IO_SENSOR_ON_OUT] == $past(sensor_on_out[0])
    && axes_one_two_io_status[HALF_W + IO_RUN_OUT] == $past(run_out[1]))
    else $error("output status bit mismatch");

  zu_gp_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    FOUR_AXIS |=> axes_three_four_io_status[HALF_W + IO_GP_OUT] == $past(gp_out[3]))
    else $error("fourth general output bit mismatch");

  prog_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !program_running |=> $stable(task_one_running_program))
    else $error("program word changed while idle");

  prog_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    task_one_running_program <= PROG_MAX)
    else $error("program word out of range");

  read_pure_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !program_running |=> $stable(task_one_running_program))
    else $error("command disturbed program word");

  idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cmd_valid |=> !rd_valid && !wr_done && !rd_miss && rd_data == WORD_RESET)
    else $error("answer without a command");

  miss_no_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_miss |-> rd_valid && rd_data == WORD_RESET)
    else $error("miss carried read data");

  absent_task_a: assert property (@(posedge clk) disable iff (!rst_n)
    !FOUR_AXIS && cmd_valid && !memory_write_command
    && cmd_addr == OFS_TASK_FOUR_FAULT_CODE |=> rd_miss)
    else $error("absent task word answered in two-axis build");

  absent_zu_io_a: assert property (@(posedge clk) disable iff (!rst_n)
    !FOUR_AXIS |-> axes_three_four_io_status == WORD_RESET)
    else $error("absent i/o word not zero in two-axis build");

  sys_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !memory_write_command && cmd_addr == OFS_SYSTEM_FAULT_CODE
    |=> rd_data == low_word_half($past(system_fault_code)))
    else $error("system fault word read wrong");

  task_one_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !memory_write_command && cmd_addr == OFS_TASK_ONE_FAULT_CODE
    |=> rd_data == low_word_half($past(task_fault_code[0])))
    else $error("task one fault word read wrong");

  axis_one_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !memory_write_command && cmd_addr == OFS_AXIS_ONE_FAULT_CODE
    |=> rd_data == low_word_half($past(axis_fault_code[0])))
    else $error("axis one fault word read wrong");

  io_word_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !memory_write_command && cmd_addr == OFS_AXES_ONE_TWO_IO_STATUS
    |=> rd_data == $past(axes_one_two_io_status))
    else $error("i/o word read wrong");

  gp_bits_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> axes_one_two_io_status[IO_GP_IN] == $past(gp_in[0])
    && axes_one_two_io_status[HALF_W + IO_GP_OUT] == $past(gp_out[1]))
    else $error("general i/o bit mismatch");

  alarm_bits_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> axes_one_two_io_status[IO_DRV_ALARM] == $past(drv_alarm[0])
    && axes_one_two_io_status[HALF_W + IO_ORIGIN] == $past(origin_near[1]))
    else $error("alarm or origin bit mismatch");

  zu_unused_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    axes_three_four_io_status[7:2] == 6'h00 && axes_three_four_io_status[23:18] == 6'h00)
    else $error("unused z/u i/o bits set");

  prog_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    program_running && program_number <= PROG_MAX
    |=> task_one_running_program == $past(program_number))
    else $error("running program number not taken");

  prog_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !memory_write_command && cmd_addr == OFS_TASK_ONE_RUNNING_PROGRAM
    |=> rd_data == {{(DATA_W-PROG_W){1'b0}}, $past(task_one_running_program)})
    else $error("program word read wrong");

endmodule

`default_nettype wire

// file: logic/mms_pkg.sv
/*
  Constants for the motion monitor status map: word offsets, field
  positions, widths and reset values.
  Assumes the host reaches the words with hexadecimal word addresses.
*/
`default_nettype none

package mms_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CODE_W = 16;
  localparam int HALF_W = 16;
  localparam int PROG_W = 10;

  // ----------------------------------------------------------------
  // word offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_SYSTEM_FAULT_CODE = 16'h1770;
  localparam logic [15:0] OFS_TASK_ONE_FAULT_CODE = 16'h1771;
  localparam logic [15:0] OFS_TASK_TWO_FAULT_CODE = 16'h1772;
  localparam logic [15:0] OFS_TASK_THREE_FAULT_CODE = 16'h1773;
  localparam logic [15:0] OFS_TASK_FOUR_FAULT_CODE = 16'h1774;
  localparam logic [15:0] OFS_AXIS_ONE_FAULT_CODE = 16'h1775;
  localparam logic [15:0] OFS_AXIS_TWO_FAULT_CODE = 16'h1776;
  localparam logic [15:0] OFS_AXIS_THREE_FAULT_CODE = 16'h1777;
  localparam logic [15:0] OFS_AXIS_FOUR_FAULT_CODE = 16'h1778;
  localparam logic [15:0] OFS_AXES_ONE_TWO_IO_STATUS = 16'h177B;
  localparam logic [15:0] OFS_AXES_THREE_FOUR_IO_STATUS = 16'h177C;
  localparam logic [15:0] OFS_TASK_ONE_RUNNING_PROGRAM = 16'h1784;

  // ----------------------------------------------------------------
  // bit positions inside one axis half of an i/o status word
  // ----------------------------------------------------------------
  localparam int IO_GP_IN = 0;
  localparam int IO_GP_OUT = 1;
  localparam int IO_CCW_LIMIT = 8;
  localparam int IO_CW_LIMIT = 9;
  localparam int IO_ORIGIN = 10;
  localparam int IO_ESTOP = 11;
  localparam int IO_DRV_ALARM = 12;
  localparam int IO_RUN_OUT = 13;
  localparam int IO_ALARM_RESET_OUT = 14;
  localparam int IO_SENSOR_ON_OUT = 15;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [9:0] PROG_MAX = 10'h3E7;
  localparam logic [9:0] PROG_RESET = 10'h000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

endpackage

`default_nettype wire

// file: dv/mms_host_model.sv
/*
  Host model: issues one memory read or write command per clock.
  Assumes the bench calls issue and idle from one process only.
*/
`timescale 1ns/1ps
`default_nettype none
module mms_host_model
  import mms_pkg::*;
(
  input wire logic clk,
  output logic cmd_valid,
  output logic memory_write_command,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [DATA_W-1:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    memory_write_command = 1'b0;
    cmd_addr = 16'h0000;
    cmd_wdata = 32'h0000_0000;
  end

  task issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    memory_write_command <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
  endtask

  // released lines flip so a stale value is never mistaken for a command
  task idle();
    @(posedge clk);
    cmd_valid <= 1'b0;
    memory_write_command <= ~memory_write_command;
    cmd_addr <= ~cmd_addr;
    cmd_wdata <= ~cmd_wdata;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/*
  Self-checking bench: a four-axis and a two-axis build share inputs.
  Assumes the host model drives the command port of both.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mms_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid, memory_write_command;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_wdata;
  logic sys_act, prun;
  logic [CODE_W-1:0] sys_code;
  logic [3:0][CODE_W-1:0] task_code, axis_code;
  logic [3:0] gpi, gpo, ccw, cw, org, es, da, ro, ar, so;
  logic [PROG_W-1:0] pnum, prog_hold;
  logic rv4, miss4, wd4, rv2, miss2, wd2;
  logic [DATA_W-1:0] rd4, rd2;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'hC8F9C479;
  logic [33:0] q4[$];
  logic [33:0] q2[$];
  logic [15:0] addrs[14] = '{16'h1770, 16'h1771, 16'h1772, 16'h1773, 16'h1774, 16'h1775,
    16'h1776, 16'h1777, 16'h1778, 16'h177B, 16'h177C, 16'h1784, 16'h1779, 16'h1700};

  always #5 clk = ~clk;

  mms_host_model mms_host_model_inst (.clk(clk), .cmd_valid(cmd_valid),
    .memory_write_command(memory_write_command), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
  mms_status_map #(.FOUR_AXIS(1'b1)) mms_status_map_inst (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .memory_write_command(memory_write_command), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .system_fault_active(sys_act), .system_fault_in(sys_code),
    .task_fault_in(task_code), .axis_fault_in(axis_code), .gp_in(gpi), .gp_out(gpo),
    .ccw_limit(ccw), .cw_limit(cw), .origin_near(org), .estop(es), .drv_alarm(da),
    .run_out(ro), .alarm_reset_out(ar), .sensor_on_out(so), .program_running(prun),
    .program_number(pnum), .rd_valid(rv4), .rd_data(rd4), .rd_miss(miss4), .wr_done(wd4));
  // two-axis build, second instance of the same module
  mms_status_map #(.FOUR_AXIS(1'b0)) mms_status_map_inst2 (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .memory_write_command(memory_write_command), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .system_fault_active(sys_act), .system_fault_in(sys_code),
    .task_fault_in(task_code), .axis_fault_in(axis_code), .gp_in(gpi), .gp_out(gpo),
    .ccw_limit(ccw), .cw_limit(cw), .origin_near(org), .estop(es), .drv_alarm(da),
    .run_out(ro), .alarm_reset_out(ar), .sensor_on_out(so), .program_running(prun),
    .program_number(pnum), .rd_valid(rv2), .rd_data(rd2), .rd_miss(miss2), .wr_done(wd2));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] half(int a);
    return {so[a], ar[a], ro[a], da[a], es[a], org[a], cw[a], ccw[a], 6'h00, gpo[a], gpi[a]};
  endfunction

  // {miss, data} that a read of address a must return
  function automatic logic [32:0] exp_word(logic [15:0] a, logic four);
    logic [31:0] d;
    logic m;
    d = 32'h0000_0000;
    m = 1'b0;
    if (a == OFS_SYSTEM_FAULT_CODE) d[15:0] = sys_act ? sys_code : CODE_NONE;
    else if (a >= OFS_TASK_ONE_FAULT_CODE && a <= OFS_TASK_FOUR_FAULT_CODE)
      d[15:0] = task_code[a - OFS_TASK_ONE_FAULT_CODE];
    else if (a >= OFS_AXIS_ONE_FAULT_CODE && a <= OFS_AXIS_FOUR_FAULT_CODE)
      d[15:0] = axis_code[a - OFS_AXIS_ONE_FAULT_CODE];
    else if (a == OFS_AXES_ONE_TWO_IO_STATUS) d = {half(1), half(0)};
    else if (a == OFS_AXES_THREE_FOUR_IO_STATUS) d = {half(3), half(2)};
    else if (a == OFS_TASK_ONE_RUNNING_PROGRAM) d[9:0] = prog_hold;
    else m = 1'b1;
    if (!four && (a inside {16'h1773, 16'h1774, 16'h1777, 16'h1778, 16'h177C})) m = 1'b1;
    if (m) d = 32'h0000_0000;
    return {m, d};
  endfunction

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t read data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_rsp(input logic two, input logic v, input logic w, input logic m,
                           input logic [31:0] dt);
    logic [33:0] e;
    if (reset_n && $isunknown({v, w})) begin
      mismatches++;
      $display("ERROR %0t answer flag unknown", $time);
      return;
    end
    if (v !== 1'b1 && w !== 1'b1) return;
    if ((two ? q2.size() : q4.size()) == 0) begin
      mismatches++;
      $display("ERROR %0t answer without command", $time);
      return;
    end
    e = two ? q2.pop_front() : q4.pop_front();
    cmp_bit(w, e[33], "write done");
    cmp_bit(v, ~e[33], "read valid");
    cmp_bit(m, e[32], "read miss");
    cmp_word(dt, e[31:0]);
  endtask

  always @(posedge clk) begin
    check_rsp(1'b0, rv4, wd4, miss4, rd4);
    check_rsp(1'b1, rv2, wd2, miss2, rd2);
  end

  task automatic cmd(input logic wr, input logic [15:0] a);
    q4.push_back({wr, wr ? 33'h0_0000_0000 : exp_word(a, 1'b1)});
    q2.push_back({wr, wr ? 33'h0_0000_0000 : exp_word(a, 1'b0)});
    mms_host_model_inst.issue(wr, a, xs());
  endtask

  task automatic read_all();
    foreach (addrs[i]) cmd(1'b0, addrs[i]);
    mms_host_model_inst.idle();
  endtask

  task automatic randomize_inputs(input int i);
    logic [31:0] r;
    @(posedge clk);
    r = xs();
    sys_act <= r[0];
    sys_code <= r[31:16];
    task_code <= {xs(), xs()};
    axis_code <= {xs(), xs()};
    {gpi, gpo, ccw, cw, org, es, da, ro} <= xs();
    r = xs();
    {ar, so} <= r[7:0];
    prun <= (i % 4 != 1);
    pnum <= (i % 4 == 0) ? PROG_MAX : (i % 4 == 3) ? 10'h3E8 : r[17:8];
    #1;
    if (prun && pnum <= PROG_MAX) prog_hold = pnum;
  endtask

  task automatic final_report();
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100us;
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    {sys_act, prun, sys_code, task_code, axis_code, pnum} = '0;
    {gpi, gpo, ccw, cw, org, es, da, ro, ar, so} = '0;
    prog_hold = PROG_RESET;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    // ------------------------------------------------------------
    // idle words, then random status with back-to-back reads
    // ------------------------------------------------------------
    read_all();
    for (int i = 0; i < 24; i++) begin
      randomize_inputs(i);
      repeat (3) @(posedge clk);
      read_all();
    end
    // mid-run reset: last number offered is out of range, so the word stays zero
    repeat (2) @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    prog_hold = PROG_RESET;
    repeat (3) @(posedge clk);
    read_all();
    // ------------------------------------------------------------
    // writes interleaved with reads leave every word unchanged
    // ------------------------------------------------------------
    foreach (addrs[i]) begin
      cmd(1'b1, addrs[i]);
      cmd(1'b0, addrs[i]);
    end
    mms_host_model_inst.idle();
    repeat (5) @(posedge clk);
    cmp_bit(q4.size() == 0 && q2.size() == 0, 1'b1, "answers outstanding");
    final_report();
  end
endmodule
`default_nettype wire
